// ==== hdl/hostif_pkg.sv ====
// Constants and helpers shared by the dual serial host interface
package hostif_pkg;

    // Control register window with auto-increment wrap
    localparam logic [7:0] CTRL_FIRST      = 8'h20;
    localparam logic [7:0] CTRL_LAST       = 8'h27;
    localparam int         CTRL_COUNT      = 8;
    localparam logic [7:0] CTRL2_ADDR      = 8'h21;

    // Bit positions inside control 2 (drive, range)
    localparam int         DRIVE_BIT_POS   = 5;
    localparam int         RANGE_BIT_POS   = 6;

    // Values after reset
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic       DRIVE_RESET     = 1'b0;
    localparam logic       RANGE_RESET     = 1'b0;
    localparam logic [7:0] ADDR_CNT_RESET  = 8'h00;

    // Upper six bits of the bus address, strap bit follows
    localparam logic [5:0] BUS_ADDR_BASE   = 6'h06;

    // Frame geometry
    localparam logic [2:0] LAST_BIT        = 3'h7;
    localparam logic [7:0] SPI_IDLE_BYTE   = 8'h00;

    // Bus rates and reference clock, for the oversampling budget
    localparam int         REF_CLK_KHZ     = 40000;
    localparam int         I2C_STD_KHZ     = 100;
    localparam int         I2C_FAST_KHZ    = 400;
    localparam int         SCL_OVERSAMPLE  = REF_CLK_KHZ / I2C_FAST_KHZ;

    // True inside the control window
    function automatic logic is_ctrl(input logic [7:0] a);
        is_ctrl = (a >= CTRL_FIRST) && (a <= CTRL_LAST);
    endfunction

    // Next address: wraps last control address back to the first
    function automatic logic [7:0] nxt_addr(input logic [7:0] a);
        if (a == CTRL_LAST) begin
            nxt_addr = CTRL_FIRST;
        end else begin
            nxt_addr = 8'(a + 8'h01);
        end
    endfunction

endpackage

// ==== hdl/dual_serial_host_interface.sv ====
// SPI mode-3 and I2C slave register port with control byte storage
//
// Contract
// - chip select low SPI, high I2C
// - SPI frame: flag, 7-bit address, data
// - SPI samples rising, shifts out falling
// - chip select low opens, high ends frame
// - SPI write stores only after sixteen clocks
// - SPI address increments 20h..27h with wrap
// - SPI read data MSB first, second byte
// - continued clocking returns next address data
// - select rising floats SPI data out
// - I2C up to 100 or 400 kHz
// - acknowledge only own bus address
// - start/stop detected while SCL high
// - receiver pulls SDA low to acknowledge
// - bus address 000110, strap, direction flag
// - address byte LSB: 1 read, 0 write
// - second write byte is register address
// - I2C write address increments with wrap
// - only writable registers take data
// - read continues on host ack, else stops
// - drive select resets 0, 1 low power
// - range select resets 0, 1 wide range
// - counter holds one past last access; SPI reads leave it unchanged
// - I2C read address increments with wrap
`timescale 1ns/10ps

module dual_serial_host_interface
    import hostif_pkg::*;
(
    input  wire logic       ref_clk,           // 40 MHz core clock
    input  wire logic       reset_n,           // Async reset, active low
    input  wire logic       chip_select_n,     // Select pin, also mode pin
    input  wire logic       spi_clock_in,      // SPI serial clock
    input  wire logic       spi_data_in,       // SPI serial data in
    output logic            spi_data_out,      // SPI serial data out
    output logic            spi_data_out_en_n, // Low while driving out
    input  wire logic       scl_in,            // I2C clock pin level
    input  wire logic       sda_in,            // I2C data pin level
    output logic            sda_out,           // I2C data drive value
    output logic            sda_out_en_n,      // Low while pulling SDA
    input  wire logic       bus_addr_strap,    // Bus address strap pin
    output logic [7:0]      ext_rd_addr,       // Address for outer regs
    input  wire logic [7:0] ext_rd_data,       // Outer register data
    output logic            drive_select_bit,  // 1 low power drive
    output logic            range_select_bit   // 1 wide range
);
    import hostif_pkg::*;

    typedef enum {
        I_IDLE, I_DEVADR, I_ACK_DEV, I_REGADR, I_ACK_REG,
        I_WDATA, I_ACK_WDATA, I_RDATA, I_RACK
    } i2c_state_type;

    // Control register bytes
    logic [7:0]    ctrl_ff [CTRL_COUNT];
    logic [7:0]    addr_cnt_ff;

    // SPI side, link clock domain
    logic          spi_clr;
    logic [2:0]    bit_cnt_ff;
    logic          hdr_done_ff;
    logic          rw_ff;
    logic [6:0]    spi_addr_ff;
    logic [6:0]    spi_sh_ff;
    logic [7:0]    spi_byte;
    logic [7:0]    out_sh_ff;
    logic [7:0]    spi_rd_byte;
    logic          spi_wr_tgl_ff;
    logic [7:0]    spi_wr_addr_ff;
    logic [7:0]    spi_wr_data_ff;

    // Synchronisers into ref_clk
    logic          cs_meta_ff, cs_sync_ff;
    logic          scl_meta_ff, scl_sync_ff, scl_prev_ff;
    logic          sda_meta_ff, sda_sync_ff, sda_prev_ff;
    logic          strap_meta_ff, strap_sync_ff;
    logic          tgl_meta_ff, tgl_sync_ff, tgl_prev_ff;

    // I2C engine
    i2c_state_type state_ff;
    logic [2:0]    i2c_bit_ff;
    logic [7:0]    i2c_sh_ff;
    logic [7:0]    tx_sh_ff;
    logic          ack_on_ff;
    logic          sda_oe_n_ff;
    logic          i2c_en;
    logic          scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0]    i2c_byte;
    logic [7:0]    i2c_rd_byte;
    logic          i2c_wr;
    logic          spi_wr;

    // ---------------- SPI, clocked by the host ----------------

    // Frame state is cleared by the select pin itself, so nothing
    // depends on a clock edge after the frame ends
    assign spi_clr  = chip_select_n | ~reset_n;
    assign spi_byte = {spi_sh_ff, spi_data_in};

    // Header and byte framing on rising edges
    always_ff @(posedge spi_clock_in or posedge spi_clr) begin
        if (spi_clr) begin
            bit_cnt_ff  <= 3'h0;
            hdr_done_ff <= 1'b0;
            rw_ff       <= 1'b0;
            spi_addr_ff <= 7'h00;
            spi_sh_ff   <= 7'h00;
        end else begin
            spi_sh_ff  <= spi_byte[6:0];
            bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
            if (bit_cnt_ff == LAST_BIT) begin
                if (!hdr_done_ff) begin
                    hdr_done_ff <= 1'b1;
                    rw_ff       <= spi_byte[7];
                    spi_addr_ff <= spi_byte[6:0];
                end else begin
                    // Next byte of a run goes to the next address
                    spi_addr_ff <= 7'(nxt_addr({1'b0, spi_addr_ff}));
                end
            end
        end
    end

    // Completed write byte, handed over by a toggle; a short frame
    // never reaches the sixteenth clock and stores nothing
    // Address and data hold until next toggle
    always_ff @(posedge spi_clock_in or negedge reset_n) begin
        if (!reset_n) begin
            spi_wr_tgl_ff  <= 1'b0;
            spi_wr_addr_ff <= 8'h00;
            spi_wr_data_ff <= 8'h00;
        end else if (bit_cnt_ff == LAST_BIT && hdr_done_ff
                     && !rw_ff) begin
            spi_wr_tgl_ff  <= ~spi_wr_tgl_ff;
            spi_wr_addr_ff <= {1'b0, spi_addr_ff};
            spi_wr_data_ff <= spi_byte;
        end
    end

    // Control bytes only change between frames, so the SPI side may
    // read them directly; other addresses read as zero over SPI
    // No hazard: I2C writes are gated off by the synced select during SPI reads
    assign spi_rd_byte = is_ctrl({1'b0, spi_addr_ff})
                         ? ctrl_ff[spi_addr_ff[2:0]] : SPI_IDLE_BYTE;

    // Read shifter on falling edges, reloaded after each byte
    always_ff @(negedge spi_clock_in or posedge spi_clr) begin
        if (spi_clr) begin
            out_sh_ff <= 8'h00;
        end else if (bit_cnt_ff == 3'h0 && hdr_done_ff) begin
            out_sh_ff <= spi_rd_byte;
        end else begin
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
        end
    end

    // Driven only for read frames; select high floats it at once
    assign spi_data_out      = out_sh_ff[7];
    assign spi_data_out_en_n = ~(hdr_done_ff & rw_ff);

    // ---------------- Synchronisers ----------------

    // Resets match idle levels, so no false edge
    // Two flops per pin; SCL at 400 kHz still gives about
    // SCL_OVERSAMPLE core cycles per bit, ample for edge finding
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_meta_ff    <= 1'b1;
            cs_sync_ff    <= 1'b1;
            scl_meta_ff   <= 1'b1;
            scl_sync_ff   <= 1'b1;
            scl_prev_ff   <= 1'b1;
            sda_meta_ff   <= 1'b1;
            sda_sync_ff   <= 1'b1;
            sda_prev_ff   <= 1'b1;
            strap_meta_ff <= 1'b0;
            strap_sync_ff <= 1'b0;
            tgl_meta_ff   <= 1'b0;
            tgl_sync_ff   <= 1'b0;
            tgl_prev_ff   <= 1'b0;
        end else begin
            cs_meta_ff    <= chip_select_n;
            cs_sync_ff    <= cs_meta_ff;
            scl_meta_ff   <= scl_in;
            scl_sync_ff   <= scl_meta_ff;
            scl_prev_ff   <= scl_sync_ff;
            sda_meta_ff   <= sda_in;
            sda_sync_ff   <= sda_meta_ff;
            sda_prev_ff   <= sda_sync_ff;
            strap_meta_ff <= bus_addr_strap;
            strap_sync_ff <= strap_meta_ff;
            tgl_meta_ff   <= spi_wr_tgl_ff;
            tgl_sync_ff   <= tgl_meta_ff;
            tgl_prev_ff   <= tgl_sync_ff;
        end
    end

    // Bus events, I2C only while select is high
    assign i2c_en     = cs_sync_ff;
    assign scl_rise   = scl_sync_ff & ~scl_prev_ff;
    assign scl_fall   = ~scl_sync_ff & scl_prev_ff;
    assign start_cond = scl_sync_ff & scl_prev_ff
                        & sda_prev_ff & ~sda_sync_ff;
    assign stop_cond  = scl_sync_ff & scl_prev_ff
                        & ~sda_prev_ff & sda_sync_ff;
    assign spi_wr     = tgl_sync_ff ^ tgl_prev_ff;
    assign i2c_byte   = {i2c_sh_ff[6:0], sda_sync_ff};

    // Read source for I2C: own bytes or outer registers
    assign ext_rd_addr = addr_cnt_ff;
    assign i2c_rd_byte = is_ctrl(addr_cnt_ff)
                         ? ctrl_ff[addr_cnt_ff[2:0]] : ext_rd_data;

    // Data byte landing on the eighth SCL rise of a write data byte
    assign i2c_wr = i2c_en && scl_rise && state_ff == I_WDATA
                    && i2c_bit_ff == LAST_BIT;

    // ---------------- I2C engine ----------------

    // Bit-level sequencer; a start always restarts, which also
    // serves the repeated start of a random read
    // A stray bit after an ack is harmless
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff    <= I_IDLE;
            i2c_bit_ff  <= 3'h0;
            i2c_sh_ff   <= 8'h00;
            tx_sh_ff    <= 8'h00;
            ack_on_ff   <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end else if (!i2c_en || stop_cond) begin
            state_ff    <= I_IDLE;
            sda_oe_n_ff <= 1'b1;
            ack_on_ff   <= 1'b0;
        end else if (start_cond) begin
            state_ff    <= I_DEVADR;
            i2c_bit_ff  <= 3'h0;
            sda_oe_n_ff <= 1'b1;
            ack_on_ff   <= 1'b0;
        end else if (scl_rise) begin
            case (state_ff)
                I_DEVADR, I_REGADR, I_WDATA: begin
                    i2c_sh_ff  <= i2c_byte;
                    i2c_bit_ff <= 3'(i2c_bit_ff + 3'h1);
                    if (i2c_bit_ff == LAST_BIT) begin
                        case (state_ff)
                            I_DEVADR: begin
                                if (i2c_byte[7:1] ==
                                    {BUS_ADDR_BASE, strap_sync_ff}) begin
                                    state_ff <= I_ACK_DEV;
                                end else begin
                                    state_ff <= I_IDLE;
                                end
                            end
                            I_REGADR: state_ff <= I_ACK_REG;
                            default:  state_ff <= I_ACK_WDATA;
                        endcase
                    end
                end
                I_RACK: begin
                    // No acknowledge ends the read; SDA stays free
                    if (sda_sync_ff) begin
                        state_ff <= I_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_ff)
                I_ACK_DEV, I_ACK_REG, I_ACK_WDATA: begin
                    if (!ack_on_ff) begin
                        ack_on_ff   <= 1'b1;
                        sda_oe_n_ff <= 1'b0;
                    end else begin
                        ack_on_ff   <= 1'b0;
                        sda_oe_n_ff <= 1'b1;
                        i2c_bit_ff  <= 3'h0;
                        if (state_ff == I_ACK_DEV && i2c_sh_ff[0]) begin
                            // Read: first bit out on this same edge
                            state_ff    <= I_RDATA;
                            sda_oe_n_ff <= i2c_rd_byte[7];
                            tx_sh_ff    <= {i2c_rd_byte[6:0], 1'b0};
                            i2c_bit_ff  <= 3'h1;
                        end else if (state_ff == I_ACK_DEV) begin
                            state_ff <= I_REGADR;
                        end else begin
                            state_ff <= I_WDATA;
                        end
                    end
                end
                I_RDATA: begin
                    if (i2c_bit_ff == 3'h0) begin
                        sda_oe_n_ff <= 1'b1;
                        state_ff    <= I_RACK;
                    end else begin
                        sda_oe_n_ff <= tx_sh_ff[7];
                        tx_sh_ff    <= {tx_sh_ff[6:0], 1'b0};
                        i2c_bit_ff  <= 3'(i2c_bit_ff + 3'h1);
                    end
                end
                I_RACK: begin
                    // Host acknowledged: next byte, next address
                    state_ff    <= I_RDATA;
                    sda_oe_n_ff <= i2c_rd_byte[7];
                    tx_sh_ff    <= {i2c_rd_byte[6:0], 1'b0};
                    i2c_bit_ff  <= 3'h1;
                end
                default: begin
                end
            endcase
        end
    end

    // Open drain: value is always low, enable does the work
    assign sda_out      = 1'b0;
    assign sda_out_en_n = sda_oe_n_ff;

    // Address counter, always one past the last access
    // SPI reads never move the counter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_cnt_ff <= ADDR_CNT_RESET;
        end else if (spi_wr) begin
            addr_cnt_ff <= nxt_addr(spi_wr_addr_ff);
        end else if (i2c_en && scl_rise && state_ff == I_REGADR
                     && i2c_bit_ff == LAST_BIT) begin
            addr_cnt_ff <= i2c_byte;
        end else if (i2c_wr) begin
            addr_cnt_ff <= nxt_addr(addr_cnt_ff);
        end else if (i2c_en && scl_fall && !start_cond && !stop_cond
                     && ((state_ff == I_ACK_DEV && ack_on_ff
                          && i2c_sh_ff[0]) || state_ff == I_RACK)) begin
            addr_cnt_ff <= nxt_addr(addr_cnt_ff);
        end
    end

    // Control bytes; SPI and I2C never run at once, SPI first anyway
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < CTRL_COUNT; i++) begin
                ctrl_ff[i] <= CTRL_RESET;
            end
        end else if (spi_wr) begin
            if (is_ctrl(spi_wr_addr_ff)) begin
                ctrl_ff[spi_wr_addr_ff[2:0]] <= spi_wr_data_ff;
            end
        end else if (i2c_wr && !start_cond && !stop_cond) begin
            if (is_ctrl(addr_cnt_ff)) begin
                ctrl_ff[addr_cnt_ff[2:0]] <= i2c_byte;
            end
        end
    end

    // Measurement configuration bits from control 2
    // One cycle behind the control byte
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_select_bit <= DRIVE_RESET;
            range_select_bit <= RANGE_RESET;
        end else begin
            drive_select_bit <= ctrl_ff[CTRL2_ADDR[2:0]][DRIVE_BIT_POS];
            range_select_bit <= ctrl_ff[CTRL2_ADDR[2:0]][RANGE_BIT_POS];
        end
    end

endmodule

// ==== sim/dual_serial_host_interface_assertions.sv ====
// Concurrent checks on the dual serial host interface ports
`timescale 1ns/10ps

module dual_serial_host_interface_assertions (
    input wire logic       ref_clk,           // Core clock
    input wire logic       reset_n,           // Async reset
    input wire logic       chip_select_n,     // Mode select
    input wire logic       spi_clock_in,      // SPI clock
    input wire logic       spi_data_in,       // SPI in
    input wire logic       spi_data_out,      // SPI out
    input wire logic       spi_data_out_en_n, // SPI out enable
    input wire logic       scl_in,            // SCL level
    input wire logic       sda_in,            // SDA level
    input wire logic       sda_out,           // SDA value
    input wire logic       sda_out_en_n,      // SDA pull enable
    input wire logic       bus_addr_strap,    // Address strap
    input wire logic [7:0] ext_rd_addr,       // Outer address
    input wire logic [7:0] ext_rd_data,       // Outer data
    input wire logic       drive_select_bit,  // Drive mode
    input wire logic       range_select_bit   // Range mode
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Deselect floats SPI output through the async path
    a_spi_out_float: assert property (
        chip_select_n |-> spi_data_out_en_n)
        else $error("SPI output driven while deselected");
    // Open drain: only ever pulls low
    a_sda_pull_low: assert property (
        !sda_out_en_n |-> !sda_out
            && (!$past(sda_out_en_n) || !$past(scl_in)))
        else $error("SDA driven high");
    // Control bits and counter leave reset cleared
    a_reset_values: assert property (
        $rose(reset_n) |-> !drive_select_bit && !range_select_bit
            && ext_rd_addr == 8'h00)
        else $error("Wrong values after reset");
    // A pull ends within 1000 core cycles, an acknowledge plus one byte at 400 kHz
    a_pull_bounded: assert property (
        $fell(sda_out_en_n) |-> ##[1:1000] sda_out_en_n)
        else $error("SDA held low too long");
    // Device SDA moves only while SCL is low
    a_sda_scl_low: assert property (
        $changed(sda_out_en_n) |-> !scl_in)
        else $error("SDA changed while SCL high");
    // SPI output stays floating for eight core cycles after select falls
    a_header_quiet: assert property (
        $fell(chip_select_n) |-> spi_data_out_en_n [*8])
        else $error("SPI output driven during header");
    // Selected SPI silences the I2C side
    a_i2c_quiet_spi: assert property (
        !chip_select_n [*4] |-> sda_out_en_n)
        else $error("SDA pulled during SPI mode");
    // Both ports never drive together
    a_port_exclusive: assert property (
        !spi_data_out_en_n |-> sda_out_en_n)
        else $error("SPI and I2C driving together");
endmodule

bind dual_serial_host_interface dual_serial_host_interface_assertions chk (
    .ref_clk, .reset_n, .chip_select_n, .spi_clock_in, .spi_data_in,
    .spi_data_out, .spi_data_out_en_n, .scl_in, .sda_in, .sda_out,
    .sda_out_en_n, .bus_addr_strap, .ext_rd_addr, .ext_rd_data,
    .drive_select_bit, .range_select_bit
);

// ==== sim/host_master_model.sv ====
// Host controller model: SPI mode 3 and I2C master
`timescale 1ns/10ps

module host_master_model (
    output logic      chip_select_n,     // Select, high for I2C
    output logic      spi_clock_in,      // SPI clock, idles high
    output logic      spi_data_in,       // SPI data to device
    input  wire logic spi_data_out,      // SPI data from device
    input  wire logic spi_data_out_en_n, // Low while device drives
    input  wire logic sda_out,           // Device SDA value
    input  wire logic sda_out_en_n,      // Low while device pulls
    output logic      scl_line,          // SCL wire
    output wire logic sda_line           // SDA wire with pull-up
);
    logic host_sda; // Host side of SDA, 1 releases
    int   hp;       // SCL half period in ns

    // Wired-AND of both open drains and the pull-up
    assign sda_line = host_sda & (sda_out_en_n | sda_out);

    // Idle bus: clocks high, SDA released
    initial begin
        chip_select_n = 1'b1;
        spi_clock_in  = 1'b1;
        spi_data_in   = 1'b0;
        scl_line      = 1'b1;
        host_sda      = 1'b1;
        hp            = 1250;
    end

    // One frame; SK runs only inside it, SI moves only with SK low
    task automatic spi_frame(input logic [7:0] hdr, input logic [31:0] wd,
                             input int nclk, output logic [31:0] rd);
        logic [39:0] sh;
        sh = {hdr, wd};
        rd = '0;
        #7 chip_select_n = 1'b0;
        #24;
        for (int i = 0; i < nclk; i++) begin
            spi_clock_in = 1'b0;
            spi_data_in  = sh[39];
            sh           = sh << 1;
            #24 spi_clock_in = 1'b1;
            if (i >= 8) begin
                rd = {rd[30:0], spi_data_out_en_n ? 1'bx : spi_data_out};
            end
            #24;
        end
        chip_select_n = 1'b1;
        #24;
    endtask

    // One SCL pulse; SDA set while low, sampled mid-high
    task automatic i2c_bit(input logic b, output logic s);
        host_sda = b;
        #(hp / 2) scl_line = 1'b1;
        #(hp / 2) s = sda_line;
        #(hp / 2) scl_line = 1'b0;
        #(hp / 2);
    endtask

    // Start, also usable as repeated start
    task automatic i2c_start();
        host_sda = 1'b1;
        #(hp / 2) scl_line = 1'b1;
        #(hp / 2) host_sda = 1'b0;
        #(hp / 2) scl_line = 1'b0;
        #(hp / 2);
    endtask

    task automatic i2c_stop();
        host_sda = 1'b0;
        #(hp / 2) scl_line = 1'b1;
        #(hp / 2) host_sda = 1'b1;
        #(hp / 2);
    endtask

    // Byte out, then release SDA for the device acknowledge
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(d[i], s);
        end
        i2c_bit(1'b1, s);
        ack = ~s;
    endtask

    // Byte in, then acknowledge or refuse the next one
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(1'b1, d[i]);
        end
        i2c_bit(~ack, s);
    endtask
endmodule

// ==== sim/dual_serial_host_interface_bench.sv ====
// Self-checking bench for the dual serial host interface
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    num_errors++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end end

module dual_serial_host_interface_bench;
    import hostif_pkg::*;

    logic       ref_clk, reset_n, chip_select_n, spi_clock_in, spi_data_in;
    logic       spi_data_out, spi_data_out_en_n, scl_line, sda_line;
    logic       sda_out, sda_out_en_n, bus_addr_strap;
    logic       drive_select_bit, range_select_bit;
    logic [7:0] ext_rd_addr, ext_rd_data;
    logic [7:0] ec [8];
    logic [31:0] r;
    int         num_errors, n_checks, seed;

    dual_serial_host_interface dut (
        .ref_clk, .reset_n, .chip_select_n, .spi_clock_in, .spi_data_in,
        .spi_data_out, .spi_data_out_en_n, .scl_in(scl_line),
        .sda_in(sda_line), .sda_out, .sda_out_en_n, .bus_addr_strap,
        .ext_rd_addr, .ext_rd_data, .drive_select_bit, .range_select_bit
    );
    host_master_model host (
        .chip_select_n, .spi_clock_in, .spi_data_in, .spi_data_out,
        .spi_data_out_en_n, .sda_out, .sda_out_en_n, .scl_line, .sda_line
    );

    // Outer registers: a pattern distinct from the address
    function automatic logic [7:0] outer_val(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction
    function automatic logic [7:0] step(input logic [7:0] a);
        return (a == 8'h27) ? 8'h20 : 8'(a + 8'h01);
    endfunction
    // SPI has no path to outer data, so it reads zero there
    function automatic logic [7:0] exp_at(input logic [7:0] a, input logic s);
        if (a >= 8'h20 && a <= 8'h27) return ec[a[2:0]];
        return s ? 8'h00 : outer_val(a);
    endfunction
    assign ext_rd_data = outer_val(ext_rd_addr);

    always #12.5 ref_clk = ~ref_clk;

    task automatic note_wr(input logic [7:0] a, input logic [7:0] d);
        if (a >= 8'h20 && a <= 8'h27) ec[a[2:0]] = d;
    endtask
    // Allow the crossing, then compare the control 2 bits
    task automatic chk_bits();
        repeat (8) @(posedge ref_clk);
        #2;
        `CHK("drive", ec[1][DRIVE_BIT_POS], drive_select_bit);
        `CHK("range", ec[1][RANGE_BIT_POS], range_select_bit);
    endtask
    task automatic spi_wr(input logic [7:0] a, input int n,
                          input logic [31:0] wd);
        logic [31:0] rd;
        host.spi_frame({1'b0, a[6:0]}, wd << (8 * (4 - n)), 8 + 8 * n, rd);
        for (int i = n - 1; i >= 0; i--) begin
            note_wr(a, wd[8 * i +: 8]);
            a = step(a);
        end
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic spi_rd(input logic [7:0] a, input int n);
        logic [31:0] rd;
        host.spi_frame({1'b1, a[6:0]}, 32'h0, 8 + 8 * n, rd);
        for (int i = n - 1; i >= 0; i--) begin
            `CHK("spi read", exp_at(a, 1'b1), rd[8 * i +: 8]);
            a = step(a);
        end
        repeat (6) @(posedge ref_clk);
    endtask
    // Optional wrong address; fin=0 leaves the bus for a repeated start
    task automatic i2c_wr(input logic bad, input logic [7:0] ra, input int n,
                          input logic [31:0] wd, input logic fin);
        logic       ack;
        logic [6:0] own;
        own = bus_addr_strap ? 7'h0D : 7'h0C;
        host.i2c_start();
        host.put_byte({own ^ {6'h00, bad}, 1'b0}, ack);
        `CHK("address ack", ~bad, ack);
        if (!bad) begin
            host.put_byte(ra, ack);
            `CHK("register ack", 1'b1, ack);
            for (int i = n - 1; i >= 0; i--) begin
                host.put_byte(wd[8 * i +: 8], ack);
                `CHK("data ack", 1'b1, ack);
                note_wr(ra, wd[8 * i +: 8]);
                ra = step(ra);
            end
        end
        if (fin) host.i2c_stop();
    endtask
    task automatic i2c_rd(input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        host.i2c_start();
        host.put_byte({bus_addr_strap ? 7'h0D : 7'h0C, 1'b1}, ack);
        `CHK("read address ack", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            host.get_byte(i < n - 1, d);
            `CHK("i2c read", exp_at(a, 1'b0), d);
            a = step(a);
        end
        host.i2c_stop();
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #(100000 * 25);
        num_errors++;
        complete_run();
    end

    // Main sequence: SPI first, then I2C writes at both rates and I2C reads at 400 kHz only
    initial begin
        seed = 97434;
        ref_clk = 1'b0;
        reset_n = 1'b0;
        bus_addr_strap = 1'b0;
        foreach (ec[i]) ec[i] = 8'h00;
        repeat (5) @(posedge ref_clk);
        #2 reset_n = 1'b1;
        chk_bits();
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            r[6:5] = k[1:0];
            spi_wr(CTRL2_ADDR, 1, r);
            chk_bits();
        end
        host.spi_frame(8'h21, 32'h0, 15, r);
        chk_bits();
        spi_wr(8'h26, 4, $random(seed));
        chk_bits();
        spi_rd(8'h26, 4);
        spi_wr(8'h11, 1, {24'h0, ~ec[1]});
        spi_rd(8'h11, 1);
        chk_bits();
        for (int k = 0; k < 2; k++) begin
            bus_addr_strap = k[0];
            host.hp = k ? 5000 : 1250;
            repeat (8) @(posedge ref_clk);
            i2c_wr(1'b1, 8'h00, 0, 32'h0, 1'b1);
            i2c_wr(1'b0, 8'h27, 3, $random(seed), 1'b1);
            i2c_wr(1'b0, 8'h19, 1, {24'h0, ~ec[1]}, 1'b1);
            chk_bits();
        end
        host.hp = 1250;
        i2c_wr(1'b0, 8'h26, 0, 32'h0, 1'b0);
        i2c_rd(8'h26, 4);
        i2c_rd(8'h22, 1);
        i2c_wr(1'b0, 8'h10, 0, 32'h0, 1'b0);
        i2c_rd(8'h10, 2);
        complete_run();
    end
endmodule
